// file: hw/sfc_defs.svh
// constants for the shift, flag and control execution block
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH

// status register bit positions
`define SFC_FLAG_C     3'd0
`define SFC_FLAG_Z     3'd1
`define SFC_FLAG_N     3'd2
`define SFC_FLAG_V     3'd3
`define SFC_FLAG_S     3'd4
`define SFC_FLAG_H     3'd5
`define SFC_FLAG_T     3'd6
`define SFC_FLAG_I     3'd7

// reset values
`define SFC_STATUS_REGISTER_RST   8'h00
`define SFC_CTRL_RST   8'h01
`define SFC_RESULT_RST 8'h00

// bus register byte offsets
`define SFC_ADR_CTRL   8'h00
`define SFC_ADR_STATUS_REGISTER   8'h04
`define SFC_ADR_RESULT 8'h08
`define SFC_ADR_STATE  8'h0c

// control register fields
`define SFC_CTRL_EN     0
`define SFC_CTRL_RESUME 1

// state register fields
`define SFC_STATE_HALT  0
`define SFC_STATE_SLEEP 1

`endif

// file: hw/sfc_pkg.sv
// types for the shift, flag and control execution block
package sfc_pkg;

   // operation codes delivered by the instruction decoder
   typedef enum logic [3:0] {
      nop_op                 = 4'h0,
      logical_shift_right_op = 4'h1,
      rotate_left_carry_op   = 4'h2,
      rotate_right_carry_op  = 4'h3,
      arith_shift_right_op   = 4'h4,
      bit_to_transfer_op     = 4'h5,
      transfer_to_bit_op     = 4'h6,
      overflow_set_op        = 4'h7,
      overflow_clear_op      = 4'h8,
      half_carry_set_op      = 4'h9,
      half_carry_clear_op    = 4'ha,
      signed_flag_set_op     = 4'hb,
      signed_flag_clear_op   = 4'hc,
      sleep_op               = 4'hd,
      watchdog_restart_op    = 4'he,
      break_op               = 4'hf
   } sfc_op_t;

   // execution state, one-hot
   typedef enum logic [1:0] {
      sfc_run  = 2'b01,
      sfc_halt = 2'b10
   } sfc_state_t;

endpackage

// file: hw/sfc_shift_unit.sv
// single-bit shift and rotate datapath with its flag results
`timescale 1ns/1ps
`default_nettype none

module sfc_shift_unit (
   input  wire sfc_pkg::sfc_op_t op_i,
   input  wire logic [7:0]       operand_i,
   input  wire logic             carry_i,
   output logic [7:0]            res_o,
   output logic                  c_o,
   output logic                  z_o,
   output logic                  n_o,
   output logic                  v_o
);

   // ---------------------------------------------------------------
   // datapath
   // ---------------------------------------------------------------
   // shift result and new carry; other ops pass the operand through
   always_comb begin
      res_o = operand_i;
      c_o   = carry_i;
      case (op_i)
         sfc_pkg::logical_shift_right_op: begin
            res_o = {1'b0, operand_i[7:1]};
            c_o   = operand_i[0];
         end
         sfc_pkg::rotate_left_carry_op: begin
            res_o = {operand_i[6:0], carry_i};
            c_o   = operand_i[7];
         end
         sfc_pkg::rotate_right_carry_op: begin
            res_o = {carry_i, operand_i[7:1]};
            c_o   = operand_i[0];
         end
         sfc_pkg::arith_shift_right_op: begin
            res_o = {operand_i[7], operand_i[7:1]}; // sign bit stays
            c_o   = operand_i[0];
         end
         default: begin
            res_o = operand_i;
            c_o   = carry_i;
         end
      endcase
   end

   // zero, negative and overflow from the shifted value
   assign z_o = (res_o == 8'h00);
   assign n_o = res_o[7];
   assign v_o = res_o[7] ^ c_o;

endmodule // sfc_shift_unit

`default_nettype wire

// file: hw/sfc_flag_unit.sv
// status register next value and transfer-bit insertion
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defs.svh"

module sfc_flag_unit (
   input  wire sfc_pkg::sfc_op_t op_i,
   input  wire logic [7:0]       status_register_i,
   input  wire logic [7:0]       operand_i,
   input  wire logic [2:0]       bit_sel_i,
   input  wire logic             sh_c_i,
   input  wire logic             sh_z_i,
   input  wire logic             sh_n_i,
   input  wire logic             sh_v_i,
   output logic [7:0]            status_register_o,
   output logic [7:0]            bit_res_o
);

   // ---------------------------------------------------------------
   // next status value
   // ---------------------------------------------------------------
   // each op touches only its own flags
   always_comb begin
      status_register_o    = status_register_i;
      bit_res_o = operand_i;
      case (op_i)
         sfc_pkg::logical_shift_right_op,
         sfc_pkg::rotate_left_carry_op,
         sfc_pkg::rotate_right_carry_op,
         sfc_pkg::arith_shift_right_op: begin
            status_register_o[`SFC_FLAG_C] = sh_c_i;
            status_register_o[`SFC_FLAG_Z] = sh_z_i;
            status_register_o[`SFC_FLAG_N] = sh_n_i;
            status_register_o[`SFC_FLAG_V] = sh_v_i;
         end
         sfc_pkg::bit_to_transfer_op:   status_register_o[`SFC_FLAG_T] = operand_i[bit_sel_i];
         sfc_pkg::transfer_to_bit_op:   bit_res_o[bit_sel_i] = status_register_i[`SFC_FLAG_T];
         sfc_pkg::overflow_set_op:      status_register_o[`SFC_FLAG_V] = 1'b1;
         sfc_pkg::overflow_clear_op:    status_register_o[`SFC_FLAG_V] = 1'b0;
         sfc_pkg::half_carry_set_op:    status_register_o[`SFC_FLAG_H] = 1'b1;
         sfc_pkg::half_carry_clear_op:  status_register_o[`SFC_FLAG_H] = 1'b0;
         sfc_pkg::signed_flag_set_op:   status_register_o[`SFC_FLAG_S] = 1'b1;
         sfc_pkg::signed_flag_clear_op: status_register_o[`SFC_FLAG_S] = 1'b0;
         default: begin
            status_register_o    = status_register_i;
            bit_res_o = operand_i;
         end
      endcase
   end

endmodule // sfc_flag_unit

`default_nettype wire

// file: hw/sfc_exec.sv
// shift, flag and control execution block with wishbone register access
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defs.svh"

// Function
// - logical right shift, zero into bit 7
// - rotate left through carry, one clock
// - rotate right through carry, one clock
// - arithmetic right shift keeps sign bit
// - selected source bit copied into transfer flag
// - transfer flag written into selected bit
// - set or clear overflow flag only
// - set or clear half-carry flag only
// - set or clear signed-test flag only
// - sleep request, status flags untouched
// - watchdog restart pulse, flags untouched
// - break hands control to debug logic
module sfc_exec (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   // decoder side
   input  wire logic             op_valid_i,
   input  wire sfc_pkg::sfc_op_t op_i,
   input  wire logic [7:0]       operand_i,
   input  wire logic [2:0]       bit_sel_i,
   input  wire logic             resume_i,
   output logic [7:0]            result_o,
   output logic                  result_we_o,
   output logic [7:0]            status_register_o,
   output logic                  sleep_req_o,
   output logic                  wdt_restart_o,
   output logic                  debug_break_o,
   output logic                  busy_o,
   // wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic [31:0]           wb_dat_o,
   output logic                  wb_ack_o
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   sfc_pkg::sfc_state_t state_r;
   sfc_pkg::sfc_state_t state_nxt;
   logic [7:0]          status_register_r;
   logic [7:0]          result_r;
   logic                result_we_r;
   logic                sleep_req_r;
   logic                wdt_restart_r;
   logic [7:0]          ctrl_r;
   logic                sleeping_r;
   logic                ack_r;
   logic [31:0]         rdata_r;
   logic [7:0]          sh_res;
   logic                sh_c;
   logic                sh_z;
   logic                sh_n;
   logic                sh_v;
   logic [7:0]          flag_nxt;
   logic [7:0]          bit_res;
   logic                accept;
   logic                bus_req;
   logic                bus_wr;
   logic                resume_req;

   // true for ops whose result goes back to the register file
   function automatic logic writes_result(input sfc_pkg::sfc_op_t op);
      case (op)
         sfc_pkg::logical_shift_right_op,
         sfc_pkg::rotate_left_carry_op,
         sfc_pkg::rotate_right_carry_op,
         sfc_pkg::arith_shift_right_op,
         sfc_pkg::transfer_to_bit_op: writes_result = 1'b1;
         default:                     writes_result = 1'b0;
      endcase
   endfunction

   // true for the four shift and rotate ops
   function automatic logic is_shift(input sfc_pkg::sfc_op_t op);
      case (op)
         sfc_pkg::logical_shift_right_op,
         sfc_pkg::rotate_left_carry_op,
         sfc_pkg::rotate_right_carry_op,
         sfc_pkg::arith_shift_right_op: is_shift = 1'b1;
         default:                       is_shift = 1'b0;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // datapath units
   // ---------------------------------------------------------------
   sfc_shift_unit u_shift (
      .op_i      (op_i),
      .operand_i (operand_i),
      .carry_i   (status_register_r[`SFC_FLAG_C]),
      .res_o     (sh_res),
      .c_o       (sh_c),
      .z_o       (sh_z),
      .n_o       (sh_n),
      .v_o       (sh_v)
   );

   sfc_flag_unit u_flag (
      .op_i      (op_i),
      .status_register_i    (status_register_r),
      .operand_i (operand_i),
      .bit_sel_i (bit_sel_i),
      .sh_c_i    (sh_c),
      .sh_z_i    (sh_z),
      .sh_n_i    (sh_n),
      .sh_v_i    (sh_v),
      .status_register_o    (flag_nxt),
      .bit_res_o (bit_res)
   );

   // ---------------------------------------------------------------
   // issue control
   // ---------------------------------------------------------------
   // ops are taken only when enabled and not halted by a break
   assign accept     = ce_i & op_valid_i & ctrl_r[`SFC_CTRL_EN] & (state_r == sfc_pkg::sfc_run);
   assign bus_req    = wb_cyc_i & wb_stb_i & ~ack_r;
   assign bus_wr     = bus_req & wb_we_i & wb_sel_i[0];
   assign resume_req = resume_i | (bus_wr & (wb_adr_i == `SFC_ADR_CTRL) & wb_dat_i[`SFC_CTRL_RESUME]);

   // run/halt state machine
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         sfc_pkg::sfc_run: begin
            if (accept && op_i == sfc_pkg::break_op) begin
               state_nxt = sfc_pkg::sfc_halt;
            end
         end
         sfc_pkg::sfc_halt: begin
            if (resume_req) begin
               state_nxt = sfc_pkg::sfc_run;
            end
         end
         default: state_nxt = sfc_pkg::sfc_run;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= sfc_pkg::sfc_run;
      end else if (ce_i) begin
         state_r <= state_nxt;
      end
   end

   // ---------------------------------------------------------------
   // status register
   // ---------------------------------------------------------------
   // the core update wins over a bus write in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_register_r <= `SFC_STATUS_REGISTER_RST;
      end else if (ce_i) begin
         if (accept) begin
            status_register_r <= flag_nxt;
         end else if (bus_wr && wb_adr_i == `SFC_ADR_STATUS_REGISTER) begin
            status_register_r <= wb_dat_i[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // result path
   // ---------------------------------------------------------------
   // shifted or bit-inserted value with a one-cycle write strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_r    <= `SFC_RESULT_RST;
         result_we_r <= 1'b0;
      end else if (ce_i) begin
         result_we_r <= accept & writes_result(op_i);
         if (accept && is_shift(op_i)) begin
            result_r <= sh_res;
         end else if (accept && op_i == sfc_pkg::transfer_to_bit_op) begin
            result_r <= bit_res;
         end
      end
   end

   // ---------------------------------------------------------------
   // control pulses
   // ---------------------------------------------------------------
   // sleep and watchdog requests last one cycle each
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sleep_req_r   <= 1'b0;
         wdt_restart_r <= 1'b0;
      end else if (ce_i) begin
         sleep_req_r   <= accept & (op_i == sfc_pkg::sleep_op);
         wdt_restart_r <= accept & (op_i == sfc_pkg::watchdog_restart_op);
      end
   end

   // sleep seen flag, set wins over a software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sleeping_r <= 1'b0;
      end else if (ce_i) begin
         if (accept && op_i == sfc_pkg::sleep_op) begin
            sleeping_r <= 1'b1;
         end else if (bus_wr && wb_adr_i == `SFC_ADR_STATE && wb_dat_i[`SFC_STATE_SLEEP]) begin
            sleeping_r <= 1'b0; // write one to clear
         end
      end
   end

   // ---------------------------------------------------------------
   // control register and bus slave
   // ---------------------------------------------------------------
   // enable bit; resume bit is a strobe and is not stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= `SFC_CTRL_RST;
      end else if (ce_i && bus_wr && wb_adr_i == `SFC_ADR_CTRL) begin
         ctrl_r <= {7'h00, wb_dat_i[`SFC_CTRL_EN]};
      end
   end

   // one wait state; unmapped reads return zero and still acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_r <= bus_req;
         case (wb_adr_i)
            `SFC_ADR_CTRL:   rdata_r <= {24'h00_0000, ctrl_r};
            `SFC_ADR_STATUS_REGISTER:   rdata_r <= {24'h00_0000, status_register_r};
            `SFC_ADR_RESULT: rdata_r <= {24'h00_0000, result_r};
            `SFC_ADR_STATE:  rdata_r <= {30'h0000_0000, sleeping_r, state_r == sfc_pkg::sfc_halt};
            default:         rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // outputs straight from flip-flops
   assign result_o      = result_r;
   assign result_we_o   = result_we_r;
   assign status_register_o        = status_register_r;
   assign sleep_req_o   = sleep_req_r;
   assign wdt_restart_o = wdt_restart_r;
   assign debug_break_o = state_r[1];
   assign busy_o        = state_r[1];
   assign wb_ack_o      = ack_r;
   assign wb_dat_o      = rdata_r;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_shr_result: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && op_i == sfc_pkg::logical_shift_right_op |=>
         result_o == {1'b0, $past(operand_i[7:1])} && status_register_o[`SFC_FLAG_C] == $past(operand_i[0]) && result_we_o)
      else $error("logical right shift result wrong");

   a_rotl_result: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && op_i == sfc_pkg::rotate_left_carry_op |=>
         result_o == {$past(operand_i[6:0]), $past(status_register_o[0])} && status_register_o[`SFC_FLAG_C] == $past(operand_i[7]))
      else $error("rotate left result wrong");

   a_rotr_result: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && op_i == sfc_pkg::rotate_right_carry_op |=>
         result_o == {$past(status_register_o[0]), $past(operand_i[7:1])} && status_register_o[`SFC_FLAG_C] == $past(operand_i[0]))
      else $error("rotate right result wrong");

   a_sra_sign: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && op_i == sfc_pkg::arith_shift_right_op |=>
         result_o == {$past(operand_i[7]), $past(operand_i[7:1])})
      else $error("arithmetic shift lost the sign");

   a_bitstore_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && op_i == sfc_pkg::bit_to_transfer_op |=>
         status_register_o[`SFC_FLAG_T] == $past(operand_i[bit_sel_i]) && status_register_o[5:0] == $past(status_register_o[5:0]) && !result_we_o)
      else $error("bit store wrong");

   a_bitload_insert: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && op_i == sfc_pkg::transfer_to_bit_op |=>
         result_o[$past(bit_sel_i)] == $past(status_register_o[`SFC_FLAG_T]) && status_register_o == $past(status_register_o) && result_we_o)
      else $error("bit load wrong");

   a_ovf_force: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && (op_i == sfc_pkg::overflow_set_op || op_i == sfc_pkg::overflow_clear_op) |=>
         status_register_o[`SFC_FLAG_V] == ($past(op_i) == sfc_pkg::overflow_set_op) && status_register_o[2:0] == $past(status_register_o[2:0]))
      else $error("overflow force wrong");

   a_half_force: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && (op_i == sfc_pkg::half_carry_set_op || op_i == sfc_pkg::half_carry_clear_op) |=>
         status_register_o[`SFC_FLAG_H] == ($past(op_i) == sfc_pkg::half_carry_set_op) && status_register_o[4:0] == $past(status_register_o[4:0]))
      else $error("half carry force wrong");

   a_sign_force: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && (op_i == sfc_pkg::signed_flag_set_op || op_i == sfc_pkg::signed_flag_clear_op) |=>
         status_register_o[`SFC_FLAG_S] == ($past(op_i) == sfc_pkg::signed_flag_set_op) && status_register_o[3:0] == $past(status_register_o[3:0]))
      else $error("signed flag force wrong");

   a_sleep_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && op_i == sfc_pkg::sleep_op |=> sleep_req_o && status_register_o == $past(status_register_o))
      else $error("sleep request missing");

   a_wdt_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && op_i == sfc_pkg::watchdog_restart_op |=> wdt_restart_o && status_register_o == $past(status_register_o))
      else $error("watchdog restart missing");

   a_break_halt: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && op_i == sfc_pkg::break_op |=> debug_break_o ##1 (!result_we_o && !sleep_req_o))
      else $error("break did not halt");

   a_shift_flags: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && is_shift(op_i) |=>
         status_register_o[`SFC_FLAG_Z] == (result_o == 8'h00) && status_register_o[`SFC_FLAG_N] == result_o[7]
         && status_register_o[`SFC_FLAG_V] == (result_o[7] ^ status_register_o[`SFC_FLAG_C]))
      else $error("shift flags wrong");

endmodule // sfc_exec

`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the shift, flag and control execution block
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
   $display("BAD %0t got %h exp %h", $time, (a), (e)); end end

module tb;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic             clk_i, rst_i, ce_i, op_valid_i, resume_i;
   sfc_pkg::sfc_op_t op_i;
   logic [7:0]       operand_i, result_o, status_register_o, wb_adr_i;
   logic [2:0]       bit_sel_i;
   logic             result_we_o, sleep_req_o, wdt_restart_o, debug_break_o, busy_o;
   logic             wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0]       wb_sel_i;
   logic [31:0]      wb_dat_i, wb_dat_o, rd;
   logic [7:0]       exp_status_register, exp_res;
   logic [7:0]       vals [5] = '{8'h81, 8'h01, 8'h80, 8'h00, 8'h7f};
   int               mismatches, checks_done;

   sfc_exec i_sfc_exec (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .op_valid_i(op_valid_i), .op_i(op_i),
      .operand_i(operand_i), .bit_sel_i(bit_sel_i), .resume_i(resume_i), .result_o(result_o),
      .result_we_o(result_we_o), .status_register_o(status_register_o), .sleep_req_o(sleep_req_o), .wdt_restart_o(wdt_restart_o),
      .debug_break_o(debug_break_o), .busy_o(busy_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

   // 250 MHz core clock
   always #2 clk_i = ~clk_i;

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   // one classic wishbone cycle, waits for ack, releases after it
   task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
      int n;
      begin
         @(posedge clk_i);
         wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= wd; wb_sel_i <= 4'hf;
         n = 0;
         do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
         q = wb_dat_o;
         if (wb_ack_o !== 1'b1) mismatches++; // no answer counts as a mismatch
         wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
      end
   endtask

   // present one op for a single cycle, then look in the answer cycle
   task automatic raw_op(input sfc_pkg::sfc_op_t op, input logic [7:0] d, input logic [2:0] b);
      @(posedge clk_i);
      op_valid_i <= 1'b1; op_i <= op; operand_i <= d; bit_sel_i <= b;
      @(posedge clk_i);
      op_valid_i <= 1'b0;
      #1;
   endtask

   // accepted op: expected result and status worked out here
   task automatic do_op(input sfc_pkg::sfc_op_t op, input logic [7:0] d, input logic [2:0] b);
      logic [7:0] r;
      logic       c, sh, w;
      begin
         r = exp_res; c = 1'b0; sh = 1'b0; w = 1'b0;
         case (op)
            sfc_pkg::logical_shift_right_op: begin r = {1'b0, d[7:1]}; c = d[0]; sh = 1'b1; end
            sfc_pkg::rotate_left_carry_op:   begin r = {d[6:0], exp_status_register[0]}; c = d[7]; sh = 1'b1; end
            sfc_pkg::rotate_right_carry_op:  begin r = {exp_status_register[0], d[7:1]}; c = d[0]; sh = 1'b1; end
            sfc_pkg::arith_shift_right_op:   begin r = {d[7], d[7:1]}; c = d[0]; sh = 1'b1; end
            sfc_pkg::bit_to_transfer_op:     exp_status_register[`SFC_FLAG_T] = d[b];
            sfc_pkg::transfer_to_bit_op:     begin r = d; r[b] = exp_status_register[`SFC_FLAG_T]; w = 1'b1; end
            sfc_pkg::overflow_set_op:        exp_status_register[`SFC_FLAG_V] = 1'b1;
            sfc_pkg::overflow_clear_op:      exp_status_register[`SFC_FLAG_V] = 1'b0;
            sfc_pkg::half_carry_set_op:      exp_status_register[`SFC_FLAG_H] = 1'b1;
            sfc_pkg::half_carry_clear_op:    exp_status_register[`SFC_FLAG_H] = 1'b0;
            sfc_pkg::signed_flag_set_op:     exp_status_register[`SFC_FLAG_S] = 1'b1;
            sfc_pkg::signed_flag_clear_op:   exp_status_register[`SFC_FLAG_S] = 1'b0;
            default: ;
         endcase
         if (sh) begin
            w = 1'b1;
            exp_status_register[`SFC_FLAG_C] = c;
            exp_status_register[`SFC_FLAG_Z] = (r == 8'h00);
            exp_status_register[`SFC_FLAG_N] = r[7];
            exp_status_register[`SFC_FLAG_V] = r[7] ^ c;
         end
         exp_res = r;
         raw_op(op, d, b);
         `CHK(result_we_o, w) // write strobe
         `CHK(result_o, exp_res) // result value
         `CHK(status_register_o, exp_status_register) // status flags
         `CHK(sleep_req_o, op == sfc_pkg::sleep_op) // sleep pulse
         `CHK(wdt_restart_o, op == sfc_pkg::watchdog_restart_op) // restart pulse
         `CHK(debug_break_o, op == sfc_pkg::break_op) // debug hand-over
      end
   endtask

   // verdict and end of run
   task automatic report_and_stop;
      if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   // main sequence
   initial begin
      clk_i = 1'b0; rst_i = 1'b1; ce_i = 1'b1; op_valid_i = 1'b0; op_i = sfc_pkg::nop_op;
      operand_i = 8'h00; bit_sel_i = 3'h0; resume_i = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0;
      wb_we_i = 1'b0; wb_adr_i = 8'h00; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
      mismatches = 0; checks_done = 0; exp_status_register = 8'h00; exp_res = 8'h00;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      // frozen clock enable swallows an op
      @(posedge clk_i); ce_i <= 1'b0; op_valid_i <= 1'b1; op_i <= sfc_pkg::overflow_set_op;
      @(posedge clk_i); ce_i <= 1'b1; op_valid_i <= 1'b0; #1;
      `CHK(status_register_o, 8'h00) // no change while frozen
      // every shift and rotate over edge operands, carry chained
      for (int k = 1; k <= 4; k++)
         foreach (vals[j]) do_op(sfc_pkg::sfc_op_t'(k), vals[j], 3'h0);
      // flag ops against all-clear and all-set backgrounds
      for (int bg = 0; bg < 2; bg++) begin
         exp_status_register = bg ? 8'hff : 8'h00;
         wb_io(1'b1, `SFC_ADR_STATUS_REGISTER, {24'h0, exp_status_register}, rd);
         for (int k = 7; k <= 12; k++) do_op(sfc_pkg::sfc_op_t'(k), 8'h00, 3'h0);
      end
      wb_io(1'b0, `SFC_ADR_STATUS_REGISTER, 32'h0, rd);
      `CHK(rd, {24'h0, exp_status_register}) // status readback
      // transfer flag to and from every bit position
      for (int b = 0; b < 8; b++) begin
         do_op(sfc_pkg::bit_to_transfer_op, 8'ha5, 3'(b));
         do_op(sfc_pkg::transfer_to_bit_op, 8'h5a, 3'(b));
      end
      // sleep and watchdog pulses, sleep-seen bit set then cleared
      do_op(sfc_pkg::sleep_op, 8'h00, 3'h0);
      do_op(sfc_pkg::watchdog_restart_op, 8'h00, 3'h0);
      wb_io(1'b0, `SFC_ADR_STATE, 32'h0, rd);
      `CHK(rd, 32'h2) // sleep seen
      wb_io(1'b1, `SFC_ADR_STATE, 32'h2, rd);
      wb_io(1'b0, `SFC_ADR_STATE, 32'h0, rd);
      `CHK(rd, 32'h0) // sleep seen cleared
      wb_io(1'b0, `SFC_ADR_RESULT, 32'h0, rd);
      `CHK(rd, {24'h0, exp_res}) // result readback
      wb_io(1'b0, 8'h20, 32'h0, rd);
      `CHK(rd, 32'h0) // unmapped reads zero
      // break halts, ops ignored until resume
      do_op(sfc_pkg::break_op, 8'h00, 3'h0);
      `CHK(busy_o, 1'b1) // halted
      raw_op(sfc_pkg::logical_shift_right_op, 8'hff, 3'h0);
      `CHK(result_we_o, 1'b0) // op ignored in halt
      `CHK(status_register_o, exp_status_register) // flags untouched
      @(posedge clk_i); resume_i <= 1'b1;
      @(posedge clk_i); resume_i <= 1'b0; #1;
      `CHK(debug_break_o, 1'b0) // resumed
      do_op(sfc_pkg::logical_shift_right_op, 8'h02, 3'h0);
      // disabled execution ignores ops
      wb_io(1'b1, `SFC_ADR_CTRL, 32'h0, rd);
      raw_op(sfc_pkg::overflow_set_op, 8'h00, 3'h0);
      `CHK(status_register_o, exp_status_register) // op ignored when disabled
      wb_io(1'b1, `SFC_ADR_CTRL, 32'h1, rd);
      do_op(sfc_pkg::overflow_set_op, 8'h00, 3'h0);
      report_and_stop();
   end

   // watchdog against a hang
   initial begin
      #20000;
      mismatches++;
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
